// file: hdl/pcg_top.sv
// pll clock generator controller: axi4-lite registers, reference select, dividers
//
// Local design decisions: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps

module pcg_div
   import pcg_pkg::*;
#(
   parameter logic [RATIO_W-1:0] RST_RATIO = '0
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic tick,
   input wire logic en,
   input wire logic [RATIO_W-1:0] ratio_m1,
   output logic clk_out
);
   logic [RATIO_W-1:0] cnt_reg;
   logic [RATIO_W-1:0] ratio_reg;
   wire last_w = (cnt_reg >= ratio_reg);

   // new ratio taken only at a toggle or while disabled, so a ratio change never cuts a half-period short
   always_ff @(posedge aclk) begin
      if (!aresetn || !en) begin
         cnt_reg <= '0;
         clk_out <= 1'b0;
         ratio_reg <= aresetn ? ratio_m1 : RST_RATIO;
      end else if (tick) begin
         cnt_reg <= last_w ? '0 : cnt_reg + 1'b1;
         if (last_w) begin
            clk_out <= ~clk_out;
            ratio_reg <= ratio_m1;
         end
      end
   end
endmodule : pcg_div

module pcg_top
   import pcg_pkg::*;
#(
   parameter int STABLE_CYCLES = STABLE_CYCLES_DEF
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic pll_output,
   input wire logic mem_clock_in,
   output logic pll_reset_ctl,
   output logic pll_powerdown,
   output logic [RATIO_W:0] pll_multiplier,
   output logic [RATIO_W:0] input_prescaler,
   output logic core_clock,
   output logic periph_bus_clock,
   output logic ext_mem_clock,
   output logic clock_out_two,
   output logic clock_out_three,
   output logic mem_clock_out
);
   logic aw_held_reg, w_held_reg;
   logic [ADDR_W-1:0] awaddr_reg;
   logic [31:0] wdata_reg;
   logic path_reg, pwrdn_reg, rst_reg, stable_reg;
   logic [31:0] stab_cnt_reg;
   logic [RATIO_W-1:0] mult_reg, pre_reg, core_reg, periph_reg, extmem_reg, osc_reg;
   logic core_en_reg, periph_en_reg, extmem_en_reg, osc_en_reg;
   logic mem_src_reg, ck2_en_reg, mem_out_en_reg;
   logic pll_prev_reg;

   // write path: address and data accepted in either order
   assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
   assign s_axi_wready = !w_held_reg && !s_axi_bvalid;
   wire aw_now = aw_held_reg || (s_axi_awvalid && s_axi_awready);
   wire w_now = w_held_reg || (s_axi_wvalid && s_axi_wready);
   wire [ADDR_W-1:0] wa = aw_held_reg ? awaddr_reg : s_axi_awaddr;
   wire [31:0] wd = w_held_reg ? wdata_reg : s_axi_wdata;
   wire do_wr = aw_now && w_now && !s_axi_bvalid;
   wire wr_lo = do_wr && s_axi_wstrb[0];
   wire wr_hi = do_wr && s_axi_wstrb[1];
   wire wa_ok = (wa == OFS_CSR) || (wa == OFS_MULT) || (wa == OFS_PRESCALE)
      || (wa == OFS_CORE) || (wa == OFS_PERIPH) || (wa == OFS_EXTMEM)
      || (wa == OFS_OSC) || (wa == OFS_DEVICE_CONFIG_REG) || (wa == OFS_MEM_IF_GLOBAL_CTL);
   wire [RATIO_W-1:0] wr_ratio = wd[RATIO_W-1:0];
   wire mult_ok = (wr_ratio >= MULT_MIN_M1) && (wr_ratio <= MULT_MAX_M1);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_reg <= 1'b0;
         w_held_reg <= 1'b0;
         awaddr_reg <= '0;
         wdata_reg <= '0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_reg <= 1'b1;
            awaddr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_reg <= 1'b1;
            wdata_reg <= s_axi_wdata;
         end
         if (do_wr) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wa_ok ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // register file; all fields live in the low two byte lanes
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         path_reg <= 1'b0;
         pwrdn_reg <= 1'b0;
         rst_reg <= 1'b1;
         mult_reg <= MULT_RST;
         pre_reg <= PRESCALE_RST;
         core_reg <= CORE_RST;
         periph_reg <= PERIPH_RST;
         extmem_reg <= EXTMEM_RST;
         osc_reg <= OSC_RST;
         core_en_reg <= 1'b1;
         periph_en_reg <= 1'b1;
         extmem_en_reg <= 1'b1;
         osc_en_reg <= 1'b1;
         mem_src_reg <= 1'b0;
         ck2_en_reg <= 1'b1;
         mem_out_en_reg <= 1'b1;
      end else begin
         if (wr_lo && wa == OFS_CSR) begin
            path_reg <= wd[CSR_PATH_BIT];
            pwrdn_reg <= wd[CSR_PWRDN_BIT];
            rst_reg <= wd[CSR_RST_BIT];
         end
         if (wr_lo && wa == OFS_MULT && mult_ok) mult_reg <= wr_ratio;
         if (wr_lo && wa == OFS_PRESCALE) pre_reg <= wr_ratio;
         if (wr_lo && wa == OFS_CORE) core_reg <= wr_ratio;
         if (wr_lo && wa == OFS_PERIPH) periph_reg <= wr_ratio;
         if (wr_lo && wa == OFS_EXTMEM) extmem_reg <= wr_ratio;
         if (wr_lo && wa == OFS_OSC) osc_reg <= wr_ratio;
         if (wr_hi && wa == OFS_CORE) core_en_reg <= wd[DIV_EN_BIT];
         if (wr_hi && wa == OFS_PERIPH) periph_en_reg <= wd[DIV_EN_BIT];
         if (wr_hi && wa == OFS_EXTMEM) extmem_en_reg <= wd[DIV_EN_BIT];
         if (wr_hi && wa == OFS_OSC) osc_en_reg <= wd[DIV_EN_BIT];
         if (wr_lo && wa == OFS_DEVICE_CONFIG_REG) mem_src_reg <= wd[MEM_SRC_BIT];
         if (wr_lo && wa == OFS_MEM_IF_GLOBAL_CTL) begin
            ck2_en_reg <= wd[CK2_EN_BIT];
            mem_out_en_reg <= wd[MEM_OUT_EN_BIT];
         end
      end
   end

   // read path: one cycle after the address is taken
   wire [31:0] div_core = 32'(core_reg) | (32'(core_en_reg) << DIV_EN_BIT);
   wire [31:0] div_periph = 32'(periph_reg) | (32'(periph_en_reg) << DIV_EN_BIT);
   wire [31:0] div_extmem = 32'(extmem_reg) | (32'(extmem_en_reg) << DIV_EN_BIT);
   wire [31:0] div_osc = 32'(osc_reg) | (32'(osc_en_reg) << DIV_EN_BIT);
   wire [31:0] csr_val = (32'(path_reg) << CSR_PATH_BIT) | (32'(pwrdn_reg) << CSR_PWRDN_BIT)
      | (32'(rst_reg) << CSR_RST_BIT) | (32'(stable_reg) << CSR_STABLE_BIT);
   wire [31:0] gbl_val = (32'(ck2_en_reg) << CK2_EN_BIT) | (32'(mem_out_en_reg) << MEM_OUT_EN_BIT);
   wire ra_ok = (s_axi_araddr == OFS_CSR) || (s_axi_araddr == OFS_MULT)
      || (s_axi_araddr == OFS_PRESCALE) || (s_axi_araddr == OFS_CORE)
      || (s_axi_araddr == OFS_PERIPH) || (s_axi_araddr == OFS_EXTMEM)
      || (s_axi_araddr == OFS_OSC) || (s_axi_araddr == OFS_DEVICE_CONFIG_REG)
      || (s_axi_araddr == OFS_MEM_IF_GLOBAL_CTL);
   wire [31:0] rd_mux =
      (s_axi_araddr == OFS_CSR) ? csr_val :
      (s_axi_araddr == OFS_MULT) ? 32'(mult_reg) :
      (s_axi_araddr == OFS_PRESCALE) ? 32'(pre_reg) :
      (s_axi_araddr == OFS_CORE) ? div_core :
      (s_axi_araddr == OFS_PERIPH) ? div_periph :
      (s_axi_araddr == OFS_EXTMEM) ? div_extmem :
      (s_axi_araddr == OFS_OSC) ? div_osc :
      (s_axi_araddr == OFS_DEVICE_CONFIG_REG) ? (32'(mem_src_reg) << MEM_SRC_BIT) :
      (s_axi_araddr == OFS_MEM_IF_GLOBAL_CTL) ? gbl_val : 32'h0000_0000;
   assign s_axi_arready = !s_axi_rvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_mux;
         s_axi_rresp <= ra_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // oscillator stabilization count, restarted by every reset
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         stab_cnt_reg <= '0;
         stable_reg <= 1'b0;
      end else if (!stable_reg) begin
         stab_cnt_reg <= stab_cnt_reg + 1'b1;
         stable_reg <= (stab_cnt_reg >= 32'(STABLE_CYCLES - 1));
      end
   end

   // reference ticks: every input clock in bypass, rising pll edges otherwise
   always_ff @(posedge aclk) begin
      if (!aresetn) pll_prev_reg <= 1'b0;
      else pll_prev_reg <= pll_output;
   end
   wire pll_tick = pll_output && !pll_prev_reg;
   wire ref_tick = path_reg ? pll_tick : 1'b1;

   // analog pll macro controls; ratio and factor given as true values
   assign pll_reset_ctl = rst_reg;
   assign pll_powerdown = pwrdn_reg;
   assign pll_multiplier = {1'b0, mult_reg} + 1'b1;
   assign input_prescaler = {1'b0, pre_reg} + 1'b1;

   logic osc_div;
   // independent dividers off the reference
   pcg_div #(.RST_RATIO(CORE_RST)) u_core (.aclk(aclk), .aresetn(aresetn),
      .tick(ref_tick), .en(core_en_reg), .ratio_m1(core_reg), .clk_out(core_clock));
   pcg_div #(.RST_RATIO(PERIPH_RST)) u_periph (.aclk(aclk), .aresetn(aresetn),
      .tick(ref_tick), .en(periph_en_reg), .ratio_m1(periph_reg),
      .clk_out(periph_bus_clock));
   pcg_div #(.RST_RATIO(EXTMEM_RST)) u_extmem (.aclk(aclk), .aresetn(aresetn),
      .tick(ref_tick), .en(extmem_en_reg), .ratio_m1(extmem_reg),
      .clk_out(ext_mem_clock));
   // undivided input clock, never the pll
   pcg_div #(.RST_RATIO(OSC_RST)) u_osc (.aclk(aclk), .aresetn(aresetn),
      .tick(1'b1), .en(osc_en_reg), .ratio_m1(osc_reg), .clk_out(osc_div));

   // registered pin gating; external memory clock is one cycle late
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         clock_out_two <= 1'b0;
         clock_out_three <= 1'b0;
         mem_clock_out <= 1'b0;
      end else begin
         clock_out_two <= periph_bus_clock && periph_en_reg && ck2_en_reg;
         clock_out_three <= osc_div && osc_en_reg;
         mem_clock_out <= mem_out_en_reg &&
            (mem_src_reg ? mem_clock_in : ext_mem_clock);
      end
   end

   sequence s_reset_pulse;
      !aresetn ##1 aresetn;
   endsequence
   property p_reset_state;
      @(posedge aclk) s_reset_pulse |-> pll_reset_ctl && !path_reg && !stable_reg;
   endproperty
   a_reset_state: assert property (p_reset_state) else $error("reset state wrong");
   property p_bypass_tick;
      @(posedge aclk) disable iff (!aresetn) !path_reg |-> ref_tick;
   endproperty
   a_bypass_tick: assert property (p_bypass_tick) else $error("bypass tick lost");
   property p_pll_tick;
      @(posedge aclk) disable iff (!aresetn)
         path_reg |-> (ref_tick == (pll_output && !$past(pll_output)));
   endproperty
   a_pll_tick: assert property (p_pll_tick) else $error("pll tick wrong");
   property p_mult_range;
      @(posedge aclk) disable iff (!aresetn) pll_multiplier >= 6'h04 && pll_multiplier <= 6'h19;
   endproperty
   a_mult_range: assert property (p_mult_range) else $error("multiplier range");
   property p_stable;
      @(posedge aclk) disable iff (!aresetn)
         (stab_cnt_reg < 32'(STABLE_CYCLES - 1) |-> !stable_reg) and (stable_reg |=> stable_reg);
   endproperty
   a_stable: assert property (p_stable) else $error("stable flag early or dropped");
   property p_clk2;
      @(posedge aclk) disable iff (!aresetn)
         clock_out_two |-> $past(periph_bus_clock && periph_en_reg && ck2_en_reg);
   endproperty
   a_clk2: assert property (p_clk2) else $error("clock_out_two ungated");
   property p_clk3;
      @(posedge aclk) disable iff (!aresetn) !osc_en_reg ##1 !osc_en_reg |-> !clock_out_three;
   endproperty
   a_clk3: assert property (p_clk3) else $error("clock_out_three ungated");
   property p_mem_src;
      @(posedge aclk) disable iff (!aresetn)
         mem_out_en_reg && mem_src_reg |=> mem_clock_out == $past(mem_clock_in);
   endproperty
   a_mem_src: assert property (p_mem_src) else $error("memory clock source wrong");
   property p_core_wr;
      @(posedge aclk) disable iff (!aresetn)
         wr_lo && wa == OFS_CORE |=> core_reg == $past(wr_ratio);
   endproperty
   a_core_wr: assert property (p_core_wr) else $error("core ratio not updated");
   property p_no_runt;
      @(posedge aclk) disable iff (!aresetn)
         core_en_reg && !(ref_tick && u_core.last_w) |=> $stable(core_clock)
            && $stable(u_core.ratio_reg);
   endproperty
   a_no_runt: assert property (p_no_runt) else $error("runt core pulse");
endmodule : pcg_top

// file: inc/pcg_pkg.sv
// constants and register map of the pll clock generator controller
// Function
// - prescaler divides input by 1..32; pll multiplies prescaled clock by 4..25.
// - undivided input clock goes through its own 1..32 divider to clock_out_three.
// - path select 0 uses input clock as reference, 1 uses pll output.
// - clock_out_two is the bus clock gated by divider enable and output enable.
// - clock_out_three is enabled by default under its output divider enable bit.
// - memory clock source bit picks internal or external clock; bit 5 enables output.
// - core, bus and memory clocks each have an independent divider from the reference.
// - multiplier and all dividers can be rewritten at run time.
// - pll reset control bit resets to 1, holding the pll in reset.
// - path select resets to 0, so system clocks come from the input clock.
// - input stable flag reads 0 until the stabilization counter finishes, then 1.
package pcg_pkg;
   localparam int ADDR_W = 8;
   localparam logic [7:0] OFS_CSR = 8'h00;
   localparam logic [7:0] OFS_MULT = 8'h10;
   localparam logic [7:0] OFS_PRESCALE = 8'h14;
   localparam logic [7:0] OFS_CORE = 8'h18;
   localparam logic [7:0] OFS_PERIPH = 8'h1C;
   localparam logic [7:0] OFS_EXTMEM = 8'h20;
   localparam logic [7:0] OFS_OSC = 8'h24;
   localparam logic [7:0] OFS_DEVICE_CONFIG_REG = 8'h28;
   localparam logic [7:0] OFS_MEM_IF_GLOBAL_CTL = 8'h2C;
   // control/status bit positions
   localparam int CSR_PATH_BIT = 0;
   localparam int CSR_PWRDN_BIT = 1;
   localparam int CSR_RST_BIT = 3;
   localparam int CSR_STABLE_BIT = 6;
   // divider registers: ratio minus one in the low field, enable at bit 15
   localparam int RATIO_W = 5;
   localparam int DIV_EN_BIT = 15;
   localparam int MEM_SRC_BIT = 4;
   localparam int CK2_EN_BIT = 3;
   localparam int MEM_OUT_EN_BIT = 5;
   // multiplier field holds factor minus one
   localparam logic [4:0] MULT_RST = 5'h07;
   localparam logic [4:0] MULT_MIN_M1 = 5'h03;
   localparam logic [4:0] MULT_MAX_M1 = 5'h18;
   localparam logic [4:0] PRESCALE_RST = 5'h00;
   localparam logic [4:0] CORE_RST = 5'h00;
   localparam logic [4:0] PERIPH_RST = 5'h01;
   localparam logic [4:0] EXTMEM_RST = 5'h03;
   localparam logic [4:0] OSC_RST = 5'h07;
   localparam int STABLE_CYCLES_DEF = 8192;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : pcg_pkg

// file: testbench/test_pll_clock_generator_ctrl.sv
// self-checking bench for the pll clock generator controller
`timescale 1ns/1ps

module test_pll_clock_generator_ctrl
   import pcg_pkg::*;
;
   logic aclk, aresetn;
   logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
   logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic pll_output, mem_clock_in, pll_reset_ctl, pll_powerdown;
   logic [RATIO_W:0] pll_multiplier, input_prescaler;
   logic core_clock, periph_bus_clock, ext_mem_clock;
   logic clock_out_two, clock_out_three, mem_clock_out;
   logic [1:0] pcnt, mcnt, rsp;
   logic [31:0] rdv;
   int mismatches = 0;
   int n_tests = 0;
   // worst-case pll lock time in 8 ns cycles
   localparam int LOCK_CYCLES = 23438;
   wire [5:0] clks = {mem_clock_out, clock_out_three, clock_out_two,
      ext_mem_clock, periph_bus_clock, core_clock};

   pcg_top #(.STABLE_CYCLES(16)) uut (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .pll_output(pll_output),
      .mem_clock_in(mem_clock_in), .pll_reset_ctl(pll_reset_ctl), .pll_powerdown(pll_powerdown),
      .pll_multiplier(pll_multiplier), .input_prescaler(input_prescaler),
      .core_clock(core_clock), .periph_bus_clock(periph_bus_clock),
      .ext_mem_clock(ext_mem_clock), .clock_out_two(clock_out_two),
      .clock_out_three(clock_out_three), .mem_clock_out(mem_clock_out));

   initial begin
      aclk = 1'h0;
      forever #4 aclk = ~aclk;
   end

   // pll clock rises every 4 cycles, external memory clock toggles every 3
   always @(posedge aclk) begin
      pcnt <= pcnt + 2'h1;
      pll_output <= pcnt[1];
      mcnt <= (mcnt == 2'h2) ? 2'h0 : mcnt + 2'h1;
      if (mcnt == 2'h2) begin
         mem_clock_in <= ~mem_clock_in;
      end
   end

   task check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task results;
      if (mismatches == 0 && n_tests > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : results

   task axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      int k;
      logic got;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      got = 1'h0;
      k = 0;
      while (!got) begin
         @(posedge aclk);
         k++;
         if (s_axi_awvalid && s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
         if (s_axi_wvalid && s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
         if (s_axi_bvalid === 1'h1) begin
            got = 1'h1;
            r = s_axi_bresp;
            s_axi_bready <= 1'h0;
         end
         if (k > 100) begin
            mismatches++;
            results();
         end
      end
   endtask : axi_wr

   task axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int k;
      logic got;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      got = 1'h0;
      k = 0;
      while (!got) begin
         @(posedge aclk);
         k++;
         if (s_axi_arvalid && s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
         if (s_axi_rvalid === 1'h1) begin
            got = 1'h1;
            d = s_axi_rdata;
            r = s_axi_rresp;
            s_axi_rready <= 1'h0;
         end
         if (k > 100) begin
            mismatches++;
            results();
         end
      end
   endtask : axi_rd

   // waits out a partial half period so a ratio change never skews the count
   task half(input int i, output int n);
      logic v;
      int k;
      for (k = 0; k < 2; k++) begin
         v = clks[i];
         n = 0;
         while (clks[i] === v && n < 300) begin
            @(posedge aclk);
            n++;
         end
      end
   endtask : half

   task per(input int i, input int exp);
      int n;
      half(i, n);
      half(i, n);
      check(n, exp);
   endtask : per

   task low_for(input int i);
      logic ok;
      ok = 1'h1;
      repeat (3) @(posedge aclk);
      repeat (70) begin
         @(posedge aclk);
         if (clks[i] !== 1'h0) ok = 1'h0;
      end
      check(ok, 1'h1);
   endtask : low_for

   task t_reset_values;
      static logic [7:0] ofs [8] = '{OFS_CSR, OFS_MULT, OFS_PRESCALE, OFS_CORE, OFS_PERIPH,
         OFS_EXTMEM, OFS_OSC, OFS_MEM_IF_GLOBAL_CTL};
      static logic [31:0] exp [8] = '{32'h8, 32'h7, 32'h0, 32'h8000, 32'h8001, 32'h8003,
         32'h8007, 32'h28};
      for (int i = 0; i < 8; i++) begin
         axi_rd(ofs[i], rdv, rsp);
         check(rdv, exp[i]);
      end
      check(pll_reset_ctl, 1'h1);
      check(pll_multiplier, 6'h08);
      per(0, 1);
      per(1, 2);
      per(2, 4);
      per(3, 2);
      per(4, 8);
      per(5, 4);
   endtask : t_reset_values

   task t_stable_and_release;
      repeat (20) @(posedge aclk);
      axi_rd(OFS_CSR, rdv, rsp);
      check(rdv, 32'h48);
      axi_wr(OFS_CSR, 32'h2, rsp);
      repeat (2) @(posedge aclk);
      check(pll_reset_ctl, 1'h0);
      check(pll_powerdown, 1'h1);
      axi_wr(OFS_CSR, 32'h0, rsp);
      repeat (2) @(posedge aclk);
      check(pll_powerdown, 1'h0);
   endtask : t_stable_and_release

   task t_dividers;
      axi_wr(OFS_PERIPH, 32'h8009, rsp);
      axi_wr(OFS_CORE, 32'h8004, rsp);
      per(0, 5);
      per(1, 10);
      per(3, 10);
      axi_wr(OFS_CORE, 32'h8000, rsp);
      axi_wr(OFS_PERIPH, 32'h8001, rsp);
      per(0, 1);
      per(1, 2);
   endtask : t_dividers

   task t_outputs;
      axi_wr(OFS_OSC, 32'h801F, rsp);
      per(4, 32);
      axi_wr(OFS_OSC, 32'h001F, rsp);
      low_for(4);
      axi_wr(OFS_OSC, 32'h8002, rsp);
      axi_wr(OFS_MEM_IF_GLOBAL_CTL, 32'h20, rsp);
      low_for(3);
      per(5, 4);
      axi_wr(OFS_MEM_IF_GLOBAL_CTL, 32'h08, rsp);
      low_for(5);
      axi_wr(OFS_MEM_IF_GLOBAL_CTL, 32'h28, rsp);
      per(3, 2);
      axi_wr(OFS_DEVICE_CONFIG_REG, 32'h10, rsp);
      per(5, 3);
      axi_wr(OFS_DEVICE_CONFIG_REG, 32'h0, rsp);
      per(5, 4);
   endtask : t_outputs

   task t_multiplier;
      static logic [31:0] wv [5] = '{32'h18, 32'h02, 32'h03, 32'h1F, 32'h00};
      static logic [7:0] wo [5] = '{OFS_MULT, OFS_MULT, OFS_MULT, OFS_PRESCALE, OFS_PRESCALE};
      static logic [5:0] ev [5] = '{6'h19, 6'h19, 6'h04, 6'h20, 6'h01};
      for (int i = 0; i < 5; i++) begin
         axi_wr(wo[i], wv[i], rsp);
         repeat (2) @(posedge aclk);
         check(i < 3 ? pll_multiplier : input_prescaler, ev[i]);
      end
   endtask : t_multiplier

   task t_pll_path;
      repeat (LOCK_CYCLES) @(posedge aclk);
      axi_wr(OFS_CSR, 32'h1, rsp);
      per(0, 4);
      per(1, 8);
      per(2, 16);
      per(4, 3);
      axi_wr(OFS_CSR, 32'h0, rsp);
      per(0, 1);
   endtask : t_pll_path

   task t_unmapped;
      axi_rd(8'h04, rdv, rsp);
      check(rsp, RESP_SLVERR);
      check(rdv, 32'h0);
      axi_wr(8'h30, 32'hFFFF, rsp);
      check(rsp, RESP_SLVERR);
      axi_rd(OFS_CORE, rdv, rsp);
      check(rdv, 32'h8000);
      // low lane only: ratio lands, enable in the upper lane is kept
      s_axi_wstrb <= 4'h1;
      axi_wr(OFS_EXTMEM, 32'h0000_0001, rsp);
      s_axi_wstrb <= 4'hF;
      axi_rd(OFS_EXTMEM, rdv, rsp);
      check(rdv, 32'h0000_8001);
      check(rsp, RESP_OKAY);
   endtask : t_unmapped

   initial begin
      #(40000 * 8);
      mismatches++;
      results();
   end

   initial begin
      aresetn = 1'h0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
      s_axi_awaddr = 8'h00;
      s_axi_araddr = 8'h00;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'hF;
      {pcnt, mcnt, pll_output, mem_clock_in} = 6'h00;
      repeat (4) @(posedge aclk);
      aresetn <= 1'h1;
      t_reset_values();
      t_stable_and_release();
      t_dividers();
      t_outputs();
      t_multiplier();
      t_pll_path();
      t_unmapped();
      results();
   end
endmodule : test_pll_clock_generator_ctrl
